/* File: alu_load_unit.sv */
/*
   Accumulator load unit: executes bit-field, octal address, indexed word
   and indexed constant loads, keeps the accumulator, its stack and flags.
   Assumes a one-cycle memory: word and bit answers valid the cycle after
   the request pulse. Commands are refused while busy is high.
*/
`timescale 1ns/1ns
module alu_load_unit
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire alu_pkg::alu_cmd_t cmd,
   output logic busy,
   output logic done,
   output logic [alu_pkg::ACC_W-1:0] acc,
   output logic [alu_pkg::ACC_W-1:0] stack_top,
   output logic negative_flag,
   output logic zero_flag,
   output logic pointer_range_flag,
   output logic mem_req,
   output alu_pkg::alu_mreq_t mem_addr,
   input wire logic [alu_pkg::WORD_W-1:0] mem_rdata,
   output logic bit_req,
   output logic [alu_pkg::BITADDR_W-1:0] bit_addr,
   input wire logic bit_rdata
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [alu_pkg::WORD_W-1:0] octal_to_bin(input logic [alu_pkg::WORD_W-1:0] v);
      logic [alu_pkg::WORD_W-1:0] r;
      r = '0;
      for (int i = 3; i >= 0; i--)
      begin
         r = 16'(r * 16'h0008) + 16'(v[i*4 +: 3]);
      end
      return r;
   endfunction : octal_to_bin

   function automatic logic [2:0] flags_of(input logic [alu_pkg::ACC_W-1:0] v, input logic p);
      logic [2:0] f;
      f = alu_pkg::FLAGS_RST;
      f[alu_pkg::FLAG_NEG] = v[alu_pkg::ACC_W-1];
      f[alu_pkg::FLAG_ZERO] = (v == alu_pkg::ACC_RST);
      f[alu_pkg::FLAG_PTR] = p;
      return f;
   endfunction : flags_of

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_BITS = 4'h2,
      ST_WORD = 4'h4,
      ST_DONE = 4'h8
   } alu_state_t;

   alu_state_t state_r;
   alu_state_t state_nxt;
   logic [alu_pkg::ACC_W-1:0] acc_r;
   logic [alu_pkg::ACC_W-1:0] acc_nxt;
   logic [alu_pkg::ACC_W-1:0] stack_r [alu_pkg::STACK_D];
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;
   logic loaded_r;
   logic [alu_pkg::CNT_W-1:0] cnt_r;
   logic [alu_pkg::CNT_W-1:0] idx_r;
   logic [alu_pkg::BITADDR_W-1:0] baddr_r;
   logic [alu_pkg::ACC_W-1:0] gather_r;
   logic bit_pend_r;
   logic mem_req_r;
   alu_pkg::alu_mreq_t mem_addr_r;
   logic done_r;
   logic busy_r;
   logic bit_req_r;
   logic push;
   logic [alu_pkg::WORD_W:0] sum;
   logic out_of_range;
   logic start;
   alu_pkg::alu_cmd_t c;

   assign c = cmd;
   assign start = cmd_valid && (state_r == ST_IDLE);
   // Push when a new load finds an earlier unstored load
   assign push = start && (c.op != alu_pkg::OP_STORE) && loaded_r;
   // Stack top after push is the current accumulator
   assign sum = (c.op == alu_pkg::OP_CONST)
      ? 17'({1'b0, push ? acc_r[alu_pkg::WORD_W-1:0] : stack_r[0][alu_pkg::WORD_W-1:0]})
      : 17'(c.operand) + 17'(push ? acc_r[alu_pkg::WORD_W-1:0] : stack_r[0][alu_pkg::WORD_W-1:0]);
   assign out_of_range = (c.op == alu_pkg::OP_CONST)
      ? ((c.operand < alu_pkg::LABEL_MIN) || (sum >= alu_pkg::TABLE_TOP))
      : (sum >= alu_pkg::WORD_MEM_TOP);

   // ----------------------------------------
   // Sequencer and datapath
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (start)
            begin
               unique case (c.op)
                  alu_pkg::OP_BITFIELD:
                  begin
                     state_nxt = ST_BITS;
                  end
                  alu_pkg::OP_OCTAL:
                  begin
                     acc_nxt = {16'h0000, octal_to_bin(c.operand)};
                     flags_nxt = flags_of(acc_nxt, 1'b0);
                     state_nxt = ST_DONE;
                  end
                  alu_pkg::OP_INDEXED, alu_pkg::OP_CONST:
                  begin
                     if (out_of_range)
                     begin
                        flags_nxt[alu_pkg::FLAG_PTR] = 1'b1;
                        state_nxt = ST_DONE;
                     end
                     else
                     begin
                        state_nxt = ST_WORD;
                     end
                  end
                  default:
                  begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_BITS:
         begin
            // Last bit was captured the edge before; gather is complete
            if (!bit_pend_r && (idx_r == cnt_r))
            begin
               acc_nxt = gather_r;
               flags_nxt = flags_of(gather_r, 1'b0);
               state_nxt = ST_DONE;
            end
         end
         ST_WORD:
         begin
            // Word answer stands the cycle after the request pulse
            if (!mem_req_r)
            begin
               acc_nxt = {16'h0000, mem_rdata};
               flags_nxt = flags_of(acc_nxt, 1'b0);
               state_nxt = ST_DONE;
            end
         end
         ST_DONE:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_IDLE;
         acc_r <= alu_pkg::ACC_RST;
         flags_r <= alu_pkg::FLAGS_RST;
      end
      else
      begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
      end
   end

   // ----------------------------------------
   // Accumulator stack
   // ----------------------------------------
   // Shift down; level eight falls off and is gone
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < alu_pkg::STACK_D; i++)
         begin
            stack_r[i] <= alu_pkg::ACC_RST;
         end
      end
      else if (push)
      begin
         stack_r[0] <= acc_r;
         for (int i = 1; i < alu_pkg::STACK_D; i++)
         begin
            stack_r[i] <= stack_r[i-1];
         end
      end
   end

   // Store cancels the pending push of the next load
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         loaded_r <= 1'b0;
      end
      else if (start)
      begin
         loaded_r <= (c.op != alu_pkg::OP_STORE);
      end
   end

   // ----------------------------------------
   // Bit gather
   // ----------------------------------------
   // One bit per two cycles, request then capture: slow but needs no wide port
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r <= alu_pkg::CNT_MIN;
         idx_r <= '0;
         baddr_r <= '0;
         gather_r <= alu_pkg::ACC_RST;
         bit_pend_r <= 1'b0;
         bit_req_r <= 1'b0;
      end
      else if (start && (c.op == alu_pkg::OP_BITFIELD))
      begin
         // Count clamped to 1..32
         cnt_r <= (c.count < alu_pkg::CNT_MIN) ? alu_pkg::CNT_MIN
            : ((c.count > alu_pkg::CNT_MAX) ? alu_pkg::CNT_MAX : c.count);
         idx_r <= '0;
         baddr_r <= c.operand[alu_pkg::BITADDR_W-1:0];
         gather_r <= alu_pkg::ACC_RST;
         bit_pend_r <= 1'b0;
         bit_req_r <= 1'b1;
      end
      else if (state_r == ST_BITS)
      begin
         if (bit_pend_r)
         begin
            gather_r[idx_r[4:0]] <= bit_rdata;
            idx_r <= idx_r + 6'h01;
            baddr_r <= baddr_r + 11'h001;
         end
         bit_pend_r <= !bit_pend_r && (idx_r != cnt_r);
         // Next request only after a capture leaves bits to fetch
         bit_req_r <= bit_pend_r && ((idx_r + 6'h01) != cnt_r);
      end
      else
      begin
         bit_req_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Memory request
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_req_r <= 1'b0;
         mem_addr_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         mem_req_r <= start && !out_of_range
            && ((c.op == alu_pkg::OP_INDEXED) || (c.op == alu_pkg::OP_CONST));
         if (start)
         begin
            mem_addr_r.is_table <= (c.op == alu_pkg::OP_CONST);
            mem_addr_r.label <= c.operand;
            mem_addr_r.addr <= sum[alu_pkg::WORD_W-1:0];
         end
         done_r <= (state_nxt == ST_DONE) || (start && (c.op == alu_pkg::OP_STORE));
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Registered so busy is a clean flop at the pin
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_r <= 1'b0;
      end
      else
      begin
         busy_r <= (state_nxt != ST_IDLE);
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign acc = acc_r;
   assign stack_top = stack_r[0];
   assign negative_flag = flags_r[alu_pkg::FLAG_NEG];
   assign zero_flag = flags_r[alu_pkg::FLAG_ZERO];
   assign pointer_range_flag = flags_r[alu_pkg::FLAG_PTR];
   assign mem_req = mem_req_r;
   assign mem_addr = mem_addr_r;
   assign bit_req = bit_req_r;
   assign bit_addr = baddr_r;
endmodule : alu_load_unit

/* File: alu_load_unit_monitor.sv */
/*
   Checker of the accumulator load unit, bound to its top module.
   Assumes one clock and the one-cycle memory answer of the unit.
*/
`timescale 1ns/1ns
module alu_load_unit_monitor
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire alu_pkg::alu_cmd_t cmd,
   input wire logic busy,
   input wire logic done,
   input wire logic [alu_pkg::ACC_W-1:0] acc,
   input wire logic [alu_pkg::ACC_W-1:0] stack_top,
   input wire logic negative_flag,
   input wire logic zero_flag,
   input wire logic pointer_range_flag,
   input wire logic mem_req,
   input wire alu_pkg::alu_mreq_t mem_addr,
   input wire logic [alu_pkg::WORD_W-1:0] mem_rdata,
   input wire logic bit_req,
   input wire logic [alu_pkg::BITADDR_W-1:0] bit_addr,
   input wire logic bit_rdata
);
   // ----------------
   // Helper state
   // ----------------
   logic last_ld_r;
   wire take = cmd_valid && !busy;
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         last_ld_r <= 1'b0;
      else if (take)
         last_ld_r <= (cmd.op != alu_pkg::OP_STORE);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------
   // Properties
   // ----------------
   neg_follows_a: assert property (done |-> negative_flag == acc[31])
      else $error("sign flag wrong");
   zero_on_load_a: assert property ($changed(acc) && acc == 32'h0 |-> zero_flag)
      else $error("zero flag missing");
   word_result_a: assert property (mem_req |-> ##2 done && acc == {16'h0, $past(mem_rdata)})
      else $error("word load result wrong");
   ptr_clear_a: assert property (mem_req |-> ##2 !pointer_range_flag)
      else $error("range flag stuck");
   push_prev_a: assert property (take && cmd.op != alu_pkg::OP_STORE && last_ld_r |=> stack_top == $past(acc))
      else $error("push missing");
   octal_timing_a: assert property (take && cmd.op == alu_pkg::OP_OCTAL |=> done && acc[31:12] == 20'h0)
      else $error("octal load late or wide");
   bit_walk_a: assert property (bit_req ##2 bit_req |-> bit_addr == $past(bit_addr, 2) + 11'h001)
      else $error("bit address not stepping");
   store_keeps_a: assert property (take && cmd.op == alu_pkg::OP_STORE |=> done && $stable(stack_top))
      else $error("store marker disturbed stack");
endmodule : alu_load_unit_monitor

bind alu_load_unit alu_load_unit_monitor u_mon
(
   .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .done(done),
   .acc(acc), .stack_top(stack_top), .negative_flag(negative_flag), .zero_flag(zero_flag),
   .pointer_range_flag(pointer_range_flag), .mem_req(mem_req), .mem_addr(mem_addr),
   .mem_rdata(mem_rdata), .bit_req(bit_req), .bit_addr(bit_addr), .bit_rdata(bit_rdata)
);

/* File: alu_pkg.sv */
/*
   Package of the accumulator load unit: widths, opcodes, flag layout,
   memory ranges and carrier structs.
   Assumes one scan clock and an external memory that answers a word or
   bit read in the cycle after the request.
*/
// Behaviour
// - Bit-field load gathers 1 to 32 bits
// - Unfilled accumulator bits cleared to zero
// - Negative flag follows accumulator sign bit
// - Zero flag set when loaded value zero
// - Consecutive loads push earlier value onto stack
// - Address load converts octal operand to binary
// - Indexed load reads base plus stack top
// - Indexed load clears accumulator upper half
// - Pointer flag raised on out-of-range address
// - Constant load picks table entry by stack top
// - Table label ranges 1 to FFFF
// - Accumulator 32 bits, memory words 16 bits
// - Eight-deep stack, deepest entry lost on push
package alu_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int ACC_W = 32;
   localparam int WORD_W = 16;
   localparam int STACK_D = 8;
   localparam int BITADDR_W = 11;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_MIN = 6'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h20;
   localparam logic [WORD_W-1:0] LABEL_MIN = 16'h0001;
   // ----------------------------------------
   // Memory range, plain defaults
   // ----------------------------------------
   localparam logic [WORD_W:0] WORD_MEM_TOP = 17'h04000;
   localparam logic [WORD_W:0] TABLE_TOP = 17'h00100;
   // ----------------------------------------
   // Flag positions
   // ----------------------------------------
   localparam int FLAG_NEG = 0;
   localparam int FLAG_ZERO = 1;
   localparam int FLAG_PTR = 2;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [ACC_W-1:0] ACC_RST = 32'h00000000;

   typedef enum logic [2:0]
   {
      OP_BITFIELD = 3'h0,
      OP_OCTAL = 3'h1,
      OP_INDEXED = 3'h2,
      OP_CONST = 3'h3,
      OP_STORE = 3'h4
   } alu_op_t;

   typedef struct packed
   {
      alu_op_t op;
      logic [WORD_W-1:0] operand;
      logic [CNT_W-1:0] count;
   } alu_cmd_t;

   typedef struct packed
   {
      logic is_table;
      logic [WORD_W-1:0] label;
      logic [WORD_W-1:0] addr;
   } alu_mreq_t;
endpackage : alu_pkg

/* File: alu_testbench.sv */
/*
   Testbench of the accumulator load unit; word and bit memories modelled inline.
   Assumes memory answers in the cycle after each request.
*/
`timescale 1ns/1ns
`define CHK(n, g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
   logic sys_clk, arst_n, cmd_valid, busy, done, bit_req, bit_rdata, mem_req, rq, bq;
   logic negative_flag, zero_flag, pointer_range_flag, last_ld, exp_n, exp_z, exp_p;
   logic [31:0] acc, stack_top, exp_acc, exp_stk;
   logic [15:0] mem_rdata;
   logic [10:0] bit_addr, ba;
   alu_pkg::alu_cmd_t cmd;
   alu_pkg::alu_mreq_t mem_addr, mq;
   int fail_count, tests_run;
   alu_load_unit dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy),
      .done(done), .acc(acc), .stack_top(stack_top), .negative_flag(negative_flag), .zero_flag(zero_flag),
      .pointer_range_flag(pointer_range_flag), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .bit_req(bit_req), .bit_addr(bit_addr), .bit_rdata(bit_rdata));
   function automatic logic bit_of(input logic [10:0] a);
      return a[0] ^ a[2] ^ a[4] ^ a[7];
   endfunction : bit_of
   function automatic logic [15:0] word_of(input alu_pkg::alu_mreq_t m);
      return m.is_table ? ({m.label[7:0], m.addr[7:0]} ^ 16'h8001) : (m.addr ^ 16'hC35A);
   endfunction : word_of
   function automatic logic [31:0] field(input logic [10:0] s, input int n);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < n; i++)
         v[i] = bit_of(s + 11'(i));
      return v;
   endfunction : field
   // ----------------
   // Memory answers
   // ----------------
   always @(posedge sys_clk)
   begin
      rq = mem_req;
      mq = mem_addr;
      bq = bit_req;
      ba = bit_addr;
      #1;
      // Idle lines toggle so stale data never looks valid
      mem_rdata = rq ? word_of(mq) : ~mem_rdata;
      bit_rdata = bq ? bit_of(ba) : ~bit_rdata;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic ld(input alu_pkg::alu_op_t op, input logic [15:0] opd, input logic [5:0] n,
      input logic [31:0] v, input logic ok);
      int k;
      k = 0;
      if (op != alu_pkg::OP_STORE && last_ld)
         exp_stk = exp_acc;
      @(posedge sys_clk);
      #1;
      cmd = '{op: op, operand: opd, count: n};
      cmd_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b0;
      while (done !== 1'b1 && k < 100)
      begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k == 100)
      begin
         fail_count++;
         tally_and_finish();
      end
      if (op != alu_pkg::OP_STORE)
      begin
         if (ok)
         begin
            exp_acc = v;
            exp_z = (v == 32'h0);
            exp_n = v[31];
         end
         exp_p = !ok;
      end
      last_ld = (op != alu_pkg::OP_STORE);
      `CHK("acc", acc, exp_acc)
      `CHK("stack_top", stack_top, exp_stk)
      `CHK("negative_flag", negative_flag, exp_n)
      `CHK("zero_flag", zero_flag, exp_z)
      `CHK("pointer_range_flag", pointer_range_flag, exp_p)
      `CHK("busy", busy, (op != alu_pkg::OP_STORE))
   endtask : ld
   task t_bitfield;
      ld(alu_pkg::OP_BITFIELD, 16'h0000, 6'h01, field(11'h000, 1), 1'b1);
      ld(alu_pkg::OP_BITFIELD, 16'h0005, 6'h07, field(11'h005, 7), 1'b1);
      ld(alu_pkg::OP_BITFIELD, 16'h0000, 6'h20, field(11'h000, 32), 1'b1);
   endtask : t_bitfield
   task t_octal;
      ld(alu_pkg::OP_STORE, 16'h0000, 6'h00, 32'h0, 1'b1);
      ld(alu_pkg::OP_OCTAL, 16'h1234, 6'h00, 32'h0000029C, 1'b1);
      ld(alu_pkg::OP_OCTAL, 16'h0000, 6'h00, 32'h0, 1'b1);
   endtask : t_octal
   task t_indexed;
      // Last in-range word, then first address past the top
      ld(alu_pkg::OP_OCTAL, 16'h0016, 6'h00, 32'h0000000E, 1'b1);
      ld(alu_pkg::OP_INDEXED, 16'h3FF1, 6'h00, {16'h0, word_of('{1'b0, 16'h0, 16'h3FFF})}, 1'b1);
      ld(alu_pkg::OP_OCTAL, 16'h0016, 6'h00, 32'h0000000E, 1'b1);
      ld(alu_pkg::OP_INDEXED, 16'h3FF2, 6'h00, 32'h0, 1'b0);
   endtask : t_indexed
   task t_const;
      ld(alu_pkg::OP_OCTAL, 16'h0003, 6'h00, 32'h00000003, 1'b1);
      ld(alu_pkg::OP_CONST, 16'h0002, 6'h00, {16'h0, word_of('{1'b1, 16'h0002, 16'h0003})}, 1'b1);
      ld(alu_pkg::OP_OCTAL, 16'h0003, 6'h00, 32'h00000003, 1'b1);
      ld(alu_pkg::OP_CONST, 16'h0000, 6'h00, 32'h0, 1'b0);
      ld(alu_pkg::OP_OCTAL, 16'h0377, 6'h00, 32'h000000FF, 1'b1);
      ld(alu_pkg::OP_CONST, 16'hFFFF, 6'h00, {16'h0, word_of('{1'b1, 16'hFFFF, 16'h00FF})}, 1'b1);
   endtask : t_const
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial
   begin
      {arst_n, cmd_valid, mem_rdata, bit_rdata, last_ld, exp_n, exp_z, exp_p} = '0;
      cmd = '0;
      exp_acc = 32'h0;
      exp_stk = 32'h0;
      repeat (5) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      t_bitfield();
      t_octal();
      t_indexed();
      t_const();
      tally_and_finish();
   end
endmodule : testbench
